// ==== verilog/sbtap_defs.vh ====
// Purpose: Constants for the boundary-scan test access port
// Assumes: Plain Verilog-2005 includer
// Notes: Instruction codes other than fixed ones are arbitrary choices
`ifndef SBTAP_DEFS_VH
`define SBTAP_DEFS_VH
// ----------------------------------------
// Controller states
// ----------------------------------------
`define SBTAP_ST_RESET 4'h0
`define SBTAP_ST_IDLE 4'h1
`define SBTAP_ST_SEL_DR 4'h2
`define SBTAP_ST_CAP_DR 4'h3
`define SBTAP_ST_SHF_DR 4'h4
`define SBTAP_ST_EX1_DR 4'h5
`define SBTAP_ST_PAU_DR 4'h6
`define SBTAP_ST_EX2_DR 4'h7
`define SBTAP_ST_UPD_DR 4'h8
`define SBTAP_ST_SEL_IR 4'h9
`define SBTAP_ST_CAP_IR 4'hA
`define SBTAP_ST_SHF_IR 4'hB
`define SBTAP_ST_EX1_IR 4'hC
`define SBTAP_ST_PAU_IR 4'hD
`define SBTAP_ST_EX2_IR 4'hE
`define SBTAP_ST_UPD_IR 4'hF
// ----------------------------------------
// Instructions and widths
// ----------------------------------------
`define SBTAP_IR_W 3
`define SBTAP_IR_EXTEST 3'h0
`define SBTAP_IR_IDCODE 3'h1
`define SBTAP_IR_SAMPLEZ 3'h2
`define SBTAP_IR_SAMPLE 3'h4
`define SBTAP_IR_BYPASS 3'h7
`define SBTAP_IR_CAPTURE 2'h1
`define SBTAP_ID_W 32
`define SBTAP_ID_VALUE 32'h1234_5671 // Arbitrary identification value
`define SBTAP_BSR_W 16
`endif

// ==== verilog/sbtap_port.v ====
// Purpose: Boundary-scan test access port, test clock sampled by core clock
// Assumes: Test pins are asynchronous to core_clk_in, test clock much slower
// Notes: Ring width reduced to a parameter; ID value is arbitrary
//
// Operation
// - Standard sixteen-state controller; board tester drives it per the standard.
// - Test clock only advances this port; memory never waits on it.
// - Data-in and mode-select read as one when left floating.
// - Port enters reset at power-up with no test clock activity.
// - All test inputs are sampled on the rising test clock edge.
// - Mode-select at each rising edge chooses the next controller state.
// - Data-out changes only on the falling test clock edge.
// - Loaded instruction selects exactly one register between data-in and out.
// - Serial data enters at the MSB, shifting toward the LSB.
// - Data-out presents the selected register's LSB first.
// - Data-out driver enabled only in shift states, otherwise disabled.
// - Five rising edges with mode-select high reset the port.
// - Three-bit instruction updates in Update-IR, reset loads identification.
// - Capture-IR loads the two instruction LSBs with 01.
// - Bypass is one bit, capturing low.
`timescale 1ns/100ps
`default_nettype none
`include "sbtap_defs.vh"
module sbtap_port #(
  parameter BSR_W = `SBTAP_BSR_W
) (
  // Clock and reset
  input wire core_clk_in,
  input wire reset_in,
  input wire clk_en_in,
  // Test pins; pull-up modelled by treating a floating mode-select or data-in input as one
  input wire tck_in,
  input wire tms_in,
  input wire tdi_in,
  output reg tdo_out,
  output wire tdo_oe_n_out,
  // Memory ring
  input wire [BSR_W-1:0] ring_in,
  output reg [BSR_W-1:0] ring_preload_out,
  output wire ring_drive_out,
  output wire out_bus_hiz_out,
  // Status
  output reg [3:0] state_out,
  output reg [`SBTAP_IR_W-1:0] instr_out
);
// ----------------------------------------
// Pin synchronisers
// ----------------------------------------
reg [2:0] tck_s;
reg [1:0] tms_s;
reg [1:0] tdi_s;
reg [BSR_W-1:0] ring_s0;
reg [BSR_W-1:0] ring_s1;
wire tms_v = (tms_s[1] !== 1'b0);
wire tdi_v = (tdi_s[1] !== 1'b0);
wire rise = tck_s[1] & ~tck_s[2];
wire fall = ~tck_s[1] & tck_s[2];
always @(posedge core_clk_in or posedge reset_in) begin
  if (reset_in) begin
    tck_s <= 3'h0;
    tms_s <= 2'h3;
    tdi_s <= 2'h3;
    ring_s0 <= {BSR_W{1'b0}};
    ring_s1 <= {BSR_W{1'b0}};
  end else if (clk_en_in) begin
    tck_s <= {tck_s[1:0], tck_in};
    tms_s <= {tms_s[0], tms_in};
    tdi_s <= {tdi_s[0], tdi_in};
    // Memory pin ring comes from another clock domain
    ring_s0 <= ring_in;
    ring_s1 <= ring_s0;
  end
end
// ----------------------------------------
// Controller
// ----------------------------------------
reg [3:0] next_state;
always @* begin
  case (state_out)
    `SBTAP_ST_RESET: next_state = tms_v ? `SBTAP_ST_RESET : `SBTAP_ST_IDLE;
    `SBTAP_ST_IDLE: next_state = tms_v ? `SBTAP_ST_SEL_DR : `SBTAP_ST_IDLE;
    `SBTAP_ST_SEL_DR: next_state = tms_v ? `SBTAP_ST_SEL_IR : `SBTAP_ST_CAP_DR;
    `SBTAP_ST_CAP_DR: next_state = tms_v ? `SBTAP_ST_EX1_DR : `SBTAP_ST_SHF_DR;
    `SBTAP_ST_SHF_DR: next_state = tms_v ? `SBTAP_ST_EX1_DR : `SBTAP_ST_SHF_DR;
    `SBTAP_ST_EX1_DR: next_state = tms_v ? `SBTAP_ST_UPD_DR : `SBTAP_ST_PAU_DR;
    `SBTAP_ST_PAU_DR: next_state = tms_v ? `SBTAP_ST_EX2_DR : `SBTAP_ST_PAU_DR;
    `SBTAP_ST_EX2_DR: next_state = tms_v ? `SBTAP_ST_UPD_DR : `SBTAP_ST_SHF_DR;
    `SBTAP_ST_UPD_DR: next_state = tms_v ? `SBTAP_ST_SEL_DR : `SBTAP_ST_IDLE;
    `SBTAP_ST_SEL_IR: next_state = tms_v ? `SBTAP_ST_RESET : `SBTAP_ST_CAP_IR;
    `SBTAP_ST_CAP_IR: next_state = tms_v ? `SBTAP_ST_EX1_IR : `SBTAP_ST_SHF_IR;
    `SBTAP_ST_SHF_IR: next_state = tms_v ? `SBTAP_ST_EX1_IR : `SBTAP_ST_SHF_IR;
    `SBTAP_ST_EX1_IR: next_state = tms_v ? `SBTAP_ST_UPD_IR : `SBTAP_ST_PAU_IR;
    `SBTAP_ST_PAU_IR: next_state = tms_v ? `SBTAP_ST_EX2_IR : `SBTAP_ST_PAU_IR;
    `SBTAP_ST_EX2_IR: next_state = tms_v ? `SBTAP_ST_UPD_IR : `SBTAP_ST_SHF_IR;
    `SBTAP_ST_UPD_IR: next_state = tms_v ? `SBTAP_ST_SEL_DR : `SBTAP_ST_IDLE;
    default: next_state = `SBTAP_ST_RESET;
  endcase
end
// ----------------------------------------
// Shift and update registers
// ----------------------------------------
reg [`SBTAP_IR_W-1:0] ir_sh;
reg [`SBTAP_ID_W-1:0] id_sh;
reg [BSR_W-1:0] bsr_sh;
reg byp_sh;
reg hiz_latch;
wire sel_byp = (instr_out == `SBTAP_IR_BYPASS) || (instr_out == 3'h3) ||
  (instr_out == 3'h5) || (instr_out == 3'h6);
wire sel_id = (instr_out == `SBTAP_IR_IDCODE);
wire sh_dr = (state_out == `SBTAP_ST_SHF_DR);
wire sh_ir = (state_out == `SBTAP_ST_SHF_IR);
always @(posedge core_clk_in or posedge reset_in) begin
  if (reset_in) begin
    state_out <= `SBTAP_ST_RESET;
    instr_out <= `SBTAP_IR_IDCODE;
    ir_sh <= `SBTAP_IR_IDCODE;
    id_sh <= `SBTAP_ID_VALUE;
    bsr_sh <= {BSR_W{1'b0}};
    byp_sh <= 1'b0;
    ring_preload_out <= {BSR_W{1'b0}};
    hiz_latch <= 1'b0;
  end else if (clk_en_in && rise) begin
    state_out <= next_state;
    case (state_out)
      `SBTAP_ST_RESET: begin
        instr_out <= `SBTAP_IR_IDCODE;
        hiz_latch <= 1'b0;
      end
      `SBTAP_ST_CAP_IR: ir_sh <= {instr_out[2], `SBTAP_IR_CAPTURE};
      `SBTAP_ST_SHF_IR: ir_sh <= {tdi_v, ir_sh[2:1]};
      `SBTAP_ST_UPD_IR: instr_out <= ir_sh;
      `SBTAP_ST_CAP_DR: begin
        id_sh <= `SBTAP_ID_VALUE;
        byp_sh <= 1'b0;
        bsr_sh <= ring_s1;
      end
      `SBTAP_ST_SHF_DR: begin
        if (sel_byp)
          byp_sh <= tdi_v;
        else if (sel_id)
          id_sh <= {tdi_v, id_sh[`SBTAP_ID_W-1:1]};
        else
          bsr_sh <= {tdi_v, bsr_sh[BSR_W-1:1]};
      end
      `SBTAP_ST_UPD_DR: begin
        if (!sel_byp && !sel_id) begin
          ring_preload_out <= bsr_sh;
          hiz_latch <= bsr_sh[BSR_W-1];
        end
      end
      default: ;
    endcase
    // Entering reset loads the identification instruction at once
    if (next_state == `SBTAP_ST_RESET) begin
      instr_out <= `SBTAP_IR_IDCODE;
      hiz_latch <= 1'b0;
    end
  end
end
// ----------------------------------------
// Serial output on falling edge
// ----------------------------------------
reg oe;
always @(posedge core_clk_in or posedge reset_in) begin
  if (reset_in) begin
    tdo_out <= 1'b0;
    oe <= 1'b0;
  end else if (clk_en_in && fall) begin
    oe <= sh_dr | sh_ir;
    if (sh_ir)
      tdo_out <= ir_sh[0];
    else if (sel_byp)
      tdo_out <= byp_sh;
    else if (sel_id)
      tdo_out <= id_sh[0];
    else
      tdo_out <= bsr_sh[0];
  end
end
assign tdo_oe_n_out = ~oe;
assign ring_drive_out = (instr_out == `SBTAP_IR_EXTEST);
assign out_bus_hiz_out = (instr_out == `SBTAP_IR_SAMPLEZ) ||
  (ring_drive_out && hiz_latch);
endmodule
`default_nettype wire

// ==== sim/sbtap_port_props.sv ====
// Purpose: Port checks for the test access port
// Assumes: Test clock far slower than core clock
// Notes: Sees only top ports
`timescale 1ns/100ps
`default_nettype none
module sbtap_port_props (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdo_out,
  input wire logic tdo_oe_n_out,
  input wire logic ring_drive_out,
  input wire logic [3:0] state_out,
  input wire logic [2:0] instr_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  oe_in_shift_a: assert property ($fell(tdo_oe_n_out) |->
    state_out == 4'h4 || state_out == 4'hB) else $error("oe outside shift");
  tdo_on_fall_a: assert property (!$stable(tdo_out) |-> !tck_in)
    else $error("tdo moved with tck high");
  state_on_rise_a: assert property (!$stable(state_out) |-> tck_in)
    else $error("state moved with tck low");
  sel_dr_next_a: assert property ($past(state_out) == 4'h2 && state_out != 4'h2 |->
    state_out == ($past(tms_in) ? 4'h9 : 4'h3)) else $error("bad step from select");
  reset_hold_a: assert property (state_out == 4'h0 && tms_in |=> state_out == 4'h0)
    else $error("left reset with tms high");
  instr_reset_a: assert property (state_out == 4'h0 |-> ##1 instr_out == 3'h1)
    else $error("reset did not load id");
  instr_update_a: assert property (!$stable(instr_out) |->
    $past(state_out) == 4'hF || state_out == 4'hF || state_out == 4'h0) else $error("ir update");
  ext_drive_a: assert property (ring_drive_out == (instr_out == 3'h0))
    else $error("drive without extest");
endmodule
`default_nettype wire

// ==== sim/sbtap_host.sv ====
// Purpose: Board test controller model
// Assumes: 160ns test clock, idle low
// Notes: Changes pins at core edges
`timescale 1ns/100ps
`default_nettype none
module sbtap_host (
  input wire logic core_clk_in,
  input wire logic tdo_in,
  output logic tck_out,
  output logic tms_out,
  output logic tdi_out
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms_out <= m;
    tdi_out <= d;
    repeat (16) @(posedge core_clk_in);
    q = tdo_in;
    tck_out <= 1'b1;
    repeat (16) @(posedge core_clk_in);
    tck_out <= 1'b0;
  endtask
  task automatic scan(input int n, input logic [31:0] d, output logic [31:0] q);
    logic b;
    q = 32'h0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, d[i], b);
      q[i] = b;
    end
    step(1'b1, 1'b1, b);
    step(1'b0, 1'b1, b);
  endtask
endmodule
`default_nettype wire

// ==== sim/sbtap_port_tb.sv ====
// Purpose: Bench for the test access port
// Assumes: Core 200 MHz, test clock 160 ns
// Notes: Ring width 16
`timescale 1ns/100ps
`default_nettype none
`include "sbtap_defs.vh"
module sbtap_port_tb;
  logic core_clk_in = 0, reset_in = 1, tck, tms, tdi, tdo, oe_n, drv, hiz, b;
  logic [15:0] pre;
  logic [3:0] st;
  logic [2:0] ir;
  logic [31:0] q;
  int errors = 0, comparisons = 0, cyc = 0;
  initial forever #2.5 core_clk_in = ~core_clk_in;
  sbtap_host sbtap_host_inst (.core_clk_in, .tdo_in(tdo), .tck_out(tck), .tms_out(tms),
    .tdi_out(tdi));
  sbtap_port #(.BSR_W(16)) sbtap_port_inst (.core_clk_in, .reset_in, .clk_en_in(1'b1),
    .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_n_out(oe_n),
    .ring_in(16'hA5C3), .ring_preload_out(pre), .ring_drive_out(drv), .out_bus_hiz_out(hiz),
    .state_out(st), .instr_out(ir));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic shift_dr(input int n, input logic [31:0] d);
    sbtap_host_inst.step(1, 1, b);
    sbtap_host_inst.step(0, 1, b);
    sbtap_host_inst.step(0, 1, b);
    sbtap_host_inst.scan(n, d, q);
  endtask
  task automatic load_ir(input logic [2:0] v);
    sbtap_host_inst.step(1, 1, b);
    shift_dr(3, {29'h0, v});
  endtask
  task automatic t_idcode();
    check({st, ir, oe_n}, {4'h0, 3'h1, 1'b1});
    sbtap_host_inst.step(0, 1, b);
    shift_dr(32, 32'hFFFF_FFFF);
    check(q, `SBTAP_ID_VALUE);
    repeat (8) @(posedge core_clk_in);
    check(oe_n, 1'b1);
    $display("idcode end");
  endtask
  task automatic t_bypass();
    load_ir(3'h7);
    check(q[2:0], 3'h1);
    check(ir, 3'h7);
    shift_dr(8, 32'hB4);
    check(q[7:0], 8'h68);
    $display("bypass end");
  endtask
  task automatic t_sample();
    load_ir(3'h2);
    check(hiz, 1'b1);
    load_ir(3'h4);
    sbtap_host_inst.step(1, 1, b);
    sbtap_host_inst.step(0, 1, b);
    sbtap_host_inst.step(0, 1, b);
    repeat (8) @(posedge core_clk_in);
    check(oe_n, 1'b0);
    sbtap_host_inst.scan(16, 32'h3C5A, q);
    check(q[15:0], 16'hA5C3);
    check(pre, 16'h3C5A);
    check(hiz, 1'b0);
    $display("sample end");
  endtask
  task automatic t_extest_reset();
    load_ir(3'h0);
    check(drv, 1'b1);
    sbtap_host_inst.step(1, 1, b);
    sbtap_host_inst.step(0, 1, b);
    sbtap_host_inst.step(1, 1, b);
    sbtap_host_inst.step(0, 1, b);
    repeat (4) sbtap_host_inst.step(1, 1, b);
    repeat (8) @(posedge core_clk_in);
    check({st, ir, hiz}, {4'h9, 3'h0, 1'b1});
    check(pre, 16'hA5C3);
    sbtap_host_inst.step(1, 1, b);
    repeat (8) @(posedge core_clk_in);
    check({st, ir, drv, hiz}, {4'h0, 3'h1, 1'b0, 1'b0});
    $display("extest reset end");
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge core_clk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    t_idcode();
    t_bypass();
    t_sample();
    t_extest_reset();
    print_verdict();
  end
endmodule
bind sbtap_port sbtap_port_props sbtap_port_props_inst (.core_clk_in, .reset_in, .tck_in,
  .tms_in, .tdo_out, .tdo_oe_n_out, .ring_drive_out, .state_out, .instr_out);
`default_nettype wire
